// ===== hw/fps_pkg.sv
// Package of constants and types for the flash erase/program sequencer
package fps_pkg;

    // ========================================
    // Register map
    localparam logic [11:0] ADDR_OP_CONTROL = 12'h760;
    localparam logic [11:0] ADDR_UNLOCK_KEY = 12'h766;
    localparam logic [15:0] OP_CONTROL_RESET = 16'h0000;

    // ========================================
    // Control register field positions
    localparam int BIT_WRITE_START  = 15;
    localparam int BIT_WRITE_ENABLE = 14;
    localparam int BIT_WRITE_ERROR  = 13;
    localparam int BIT_ERASE_SEL    = 6;
    localparam int OPSEL_MSB        = 3;
    localparam logic [15:0] OP_CONTROL_MASK = 16'he04f;

    // ========================================
    // Operation codes and keys
    localparam logic [3:0] OPSEL_BLOCK_ERASE = 4'h2;
    localparam logic [3:0] OPSEL_ROW_PROGRAM = 4'h1;
    localparam logic [7:0] KEY_FIRST         = 8'h55;
    localparam logic [7:0] KEY_SECOND        = 8'haa;

    // ========================================
    // Array geometry
    localparam int ROWS_PER_BLOCK  = 8;
    localparam int INSTR_PER_ROW   = 64;
    localparam int INSTR_PER_BLOCK = ROWS_PER_BLOCK * INSTR_PER_ROW;
    localparam logic [9:0] ROW_WORDS_LAST   = 10'(INSTR_PER_ROW - 1);
    localparam logic [9:0] BLOCK_WORDS_LAST = 10'(INSTR_PER_BLOCK - 1);

    // ========================================
    // Timing: 200 MHz clock
    localparam int CLK_MHZ        = 200;
    localparam int PROG_STEP_NS   = 20;
    localparam int PROG_STEP_CYC  = (PROG_STEP_NS * CLK_MHZ + 999) / 1000;
    localparam logic [7:0] STEP_LAST = 8'(PROG_STEP_CYC - 1);

    // ========================================
    // State types
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ERASE,
        ST_PROGRAM
    } fps_state_t;

    typedef enum logic [1:0] {
        UK_NONE,
        UK_FIRST,
        UK_ARMED
    } fps_unlock_t;

endpackage

// ===== hw/fps_sequencer.sv
// Flash erase/program sequencer with control and unlock key registers
`timescale 1ns/1ps

// Contract
// R01: Opsel 0010 erases, 0001 programs row
// R02: Erase select bit 6, write enable 14
// R03: Software writes 55h then AAh first
// R04: No operation starts without unlock
// R05: Bit 15 starts; stall; self-clears
// R06: Erase covers eight rows, 512 words
// R07: Row program writes 64 buffered words
// R08: Software supplies block address beforehand
// R09: Software repeats row program across block
// R10: Software waits and pads two no-ops
// R11: Control resets to zero on reset
// R12: Unused bits read zero; key bits 7:0
// R13: Error flag on bad start or abort
// R14: Key writes and start must be consecutive
module fps_sequencer
    import fps_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [11:0] regAddr,
    input  wire logic [15:0] regWrData,
    input  wire logic        regWrStb,
    input  wire logic        regRdStb,
    output logic      [15:0] regRdData,
    input  wire logic [22:0] tablePage,
    input  wire logic [15:0] rowBufData,
    output logic      [5:0]  rowBufIdx,
    output logic      [22:0] flashAddr,
    output logic      [15:0] flashWrData,
    output logic             flashEraseStb,
    output logic             flashProgStb,
    input  wire logic        flashFault,
    output logic             cpuStall,
    input  wire logic        abortReq
);
    import fps_pkg::*;

    // ========================================
    // Operation overview
    //
    // Register side
    // - Two registers on a plain strobe port
    // - Control register: start, enable, error
    // - Control register: erase select, opsel
    // - Key register: write-only, low byte used
    // - Read data registered, one cycle late
    // - Read data zero in every other cycle
    // - Unmapped and key reads return zero
    // - No wait states on either strobe
    //
    // Unlock tracking
    // - First key value moves to first stage
    // - Second key after first arms the start
    // - Any other key value disarms
    // - Any non-key write disarms
    // - The arming write itself is not disarmed
    // - Reads leave the unlock stage alone
    // - Every start attempt drops the arming
    // - Cycle end and abort drop it as well
    //
    // Start decode
    // - Start bit rising from a control write
    // - Needs armed unlock and write enable
    // - Erase needs erase select with opsel
    // - Row program needs erase select clear
    // - Any mismatch raises the error flag
    // - A refused start launches nothing
    // - Base address captured at the start
    //
    // Error flag
    // - Set on refused start
    // - Set on abort or flash fault mid-cycle
    // - Cleared by writing zero while idle
    // - A set in the same cycle wins
    // - Writing one leaves the flag unchanged
    //
    // Cycle engine
    // - One word handled per step period
    // - Step period set by the package
    // - Erase walks a whole eight-row block
    // - Program walks one row of the buffer
    // - Each word gives one strobe pulse
    // - Address and data held until next pulse
    // - Erase data is driven as zero
    // - Program data taken from row buffer
    // - Buffer index follows the word counter
    //
    // Stall and completion
    // - Stall output mirrors the start bit
    // - Start bit drops with the last pulse
    // - Abort drops the start bit next cycle
    // - Control writes ignored while busy
    //
    // Hazards
    // - Row buffer read combinationally
    // - Buffer must hold steady during a cycle
    // - Table page sampled only at start
    // - Later table page changes are harmless
    // - Abort and fault are level inputs
    // - A held abort ends any launch one cycle later
    //
    // Reset
    // - Asynchronous, active low
    // - Whole state record cleared
    // - Engine and unlock back to idle
    // - No distinction between reset causes
    // - Interrupted cycle is simply lost
    //
    // Limits
    // - Word counter sized for one block
    // - Step counter sized for short steps
    // - No queueing of a second start
    // - No buffer beyond the row buffer port
    // - No interrupt logic in this block
    //
    // Timing of one erase word
    // - Step count runs from zero to last
    // - Strobe registered on the last count
    // - Counter wraps for the next word
    //
    // Timing of the launch
    // - Start write taken at an edge
    // - Stall visible after that edge
    // - First strobe a full step later
    //
    // Software view
    // - Poll or stall until start bit clears
    // - Then read error flag for the outcome
    // - Clear error before the next attempt
    // - Re-arm the unlock for every attempt
    //
    // Verification hooks
    // - Strobes are single-cycle pulses
    // - Erase and program never overlap
    // - Strobes only in the cycle after a stalled one

    // ========================================
    // State record
    typedef struct packed {
        fps_state_t  state;
        fps_unlock_t unlock;
        logic        writeStart;
        logic        writeEnable;
        logic        writeError;
        logic        eraseSel;
        logic [3:0]  opSelect;
        logic [22:0] baseAddr;
        logic [9:0]  wordCnt;
        logic [7:0]  stepCnt;
        logic [15:0] rdData;
        logic [22:0] fAddr;
        logic [15:0] fData;
        logic        eraseStb;
        logic        progStb;
    } fps_regs_t;

    fps_regs_t state_ff;
    fps_regs_t nxt_state;

    logic [15:0] controlView;
    logic        wrControl;
    logic        wrKey;
    logic        startReq;

    // Control register as software reads it
    always_comb begin
        controlView = '0;
        controlView[BIT_WRITE_START]  = state_ff.writeStart;
        controlView[BIT_WRITE_ENABLE] = state_ff.writeEnable;
        controlView[BIT_WRITE_ERROR]  = state_ff.writeError;
        controlView[BIT_ERASE_SEL]    = state_ff.eraseSel; // [R02]
        controlView[OPSEL_MSB:0]      = state_ff.opSelect;
        controlView = controlView & OP_CONTROL_MASK;       // [R12]
    end

    // Write decodes
    assign wrControl = regWrStb && (regAddr == ADDR_OP_CONTROL);
    assign wrKey     = regWrStb && (regAddr == ADDR_UNLOCK_KEY);
    assign startReq  = wrControl && regWrData[BIT_WRITE_START] && !state_ff.writeStart;

    // Next-state logic
    always_comb begin
        nxt_state = state_ff;
        nxt_state.eraseStb = 1'b0;
        nxt_state.progStb  = 1'b0;
        nxt_state.rdData   = '0;

        // Read port: data one cycle after strobe
        if (regRdStb) begin
            if (regAddr == ADDR_OP_CONTROL) begin
                nxt_state.rdData = controlView;
            end
            // Key register is write-only and reads zero [R12]
        end

        // Unlock sequence tracking
        if (wrKey) begin
            if (regWrData[7:0] == KEY_FIRST) begin // [R12]
                nxt_state.unlock = UK_FIRST;
            end else if (regWrData[7:0] == KEY_SECOND && state_ff.unlock == UK_FIRST) begin
                nxt_state.unlock = UK_ARMED; // [R03]
            end else begin
                nxt_state.unlock = UK_NONE;  // [R14]
            end
        end else if (regWrStb) begin
            nxt_state.unlock = UK_NONE;      // [R14]
        end

        // Control register writes while idle
        if (wrControl && state_ff.state == ST_IDLE) begin
            nxt_state.writeEnable = regWrData[BIT_WRITE_ENABLE];
            nxt_state.eraseSel    = regWrData[BIT_ERASE_SEL];   // [R02]
            nxt_state.opSelect    = regWrData[OPSEL_MSB:0];
            if (!regWrData[BIT_WRITE_ERROR]) begin
                nxt_state.writeError = 1'b0;
            end
        end

        // Launch of a cycle
        if (startReq && state_ff.state == ST_IDLE) begin
            if (state_ff.unlock != UK_ARMED || !regWrData[BIT_WRITE_ENABLE]) begin
                nxt_state.writeError = 1'b1; // [R04] [R13]
            end else if (regWrData[OPSEL_MSB:0] == OPSEL_BLOCK_ERASE
                         && regWrData[BIT_ERASE_SEL]) begin
                nxt_state.writeStart = 1'b1; // [R05]
                nxt_state.state      = ST_ERASE;  // [R01]
                nxt_state.baseAddr   = tablePage;
                nxt_state.wordCnt    = '0;
                nxt_state.stepCnt    = '0;
            end else if (regWrData[OPSEL_MSB:0] == OPSEL_ROW_PROGRAM
                         && !regWrData[BIT_ERASE_SEL]) begin
                nxt_state.writeStart = 1'b1; // [R05]
                nxt_state.state      = ST_PROGRAM; // [R01]
                nxt_state.baseAddr   = tablePage;
                nxt_state.wordCnt    = '0;
                nxt_state.stepCnt    = '0;
            end else begin
                nxt_state.writeError = 1'b1; // [R13]
            end
        end

        // Cycle engine
        case (state_ff.state)
            ST_IDLE: begin
            end
            ST_ERASE, ST_PROGRAM: begin
                if (abortReq || flashFault) begin
                    nxt_state.writeError = 1'b1; // [R13]
                    nxt_state.writeStart = 1'b0;
                    nxt_state.state      = ST_IDLE;
                    nxt_state.unlock     = UK_NONE;
                end else if (state_ff.stepCnt != STEP_LAST) begin
                    nxt_state.stepCnt = state_ff.stepCnt + 8'h01;
                end else begin
                    nxt_state.stepCnt = '0;
                    nxt_state.fAddr   = state_ff.baseAddr + 23'(state_ff.wordCnt);
                    if (state_ff.state == ST_ERASE) begin
                        nxt_state.eraseStb = 1'b1; // [R06]
                        nxt_state.fData    = '0;
                    end else begin
                        nxt_state.progStb = 1'b1;  // [R07]
                        nxt_state.fData   = rowBufData;
                    end
                    if ((state_ff.state == ST_ERASE && state_ff.wordCnt == BLOCK_WORDS_LAST)
                        || (state_ff.state == ST_PROGRAM
                            && state_ff.wordCnt == ROW_WORDS_LAST)) begin
                        nxt_state.writeStart = 1'b0; // [R05]
                        nxt_state.state      = ST_IDLE;
                        nxt_state.unlock     = UK_NONE;
                    end else begin
                        nxt_state.wordCnt = state_ff.wordCnt + 10'h001;
                    end
                end
            end
            default: begin
                nxt_state.state = ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff            <= '0; // [R11]
            state_ff.state      <= ST_IDLE;
            state_ff.unlock     <= UK_NONE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Outputs
    assign regRdData     = state_ff.rdData;
    assign rowBufIdx     = state_ff.wordCnt[5:0]; // [R07]
    assign flashAddr     = state_ff.fAddr;
    assign flashWrData   = state_ff.fData;
    assign flashEraseStb = state_ff.eraseStb;
    assign flashProgStb  = state_ff.progStb;
    assign cpuStall      = state_ff.writeStart;   // [R05]

endmodule

// ===== verif/fps_flash_model.sv
// Flash array and row buffer stand-in
`timescale 1ns/1ps
module fps_flash_model (
    input  wire logic        clk,
    input  wire logic [5:0]  rowBufIdx,
    input  wire logic        flashEraseStb,
    input  wire logic        flashProgStb,
    input  wire logic [15:0] flashWrData,
    input  wire logic [22:0] flashAddr,
    output logic      [15:0] rowBufData,
    output int               eraseCnt,
    output int               progCnt,
    output int               progBad,
    output logic      [22:0] lastAddr
);
    // ========================================
    // Buffer word carries its own index
    assign rowBufData = {10'h2c5, rowBufIdx};
    initial begin
        eraseCnt = 0;
        progCnt = 0;
        progBad = 0;
    end
    // Count strobes and check programmed words
    always @(posedge clk) begin
        if (flashEraseStb || flashProgStb)
            lastAddr <= flashAddr;
        if (flashEraseStb)
            eraseCnt <= eraseCnt + 1;
        if (flashProgStb)
            progCnt <= progCnt + 1;
        if (flashProgStb && flashWrData !== {10'h2c5, flashAddr[5:0]})
            progBad <= progBad + 1;
    end
endmodule

// ===== verif/fps_sequencer_checker.sv
// Port assertions for the flash sequencer
`timescale 1ns/1ps
module fps_sequencer_checker
    import fps_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic [11:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic        regWrStb,
    input wire logic        regRdStb,
    input wire logic [15:0] regRdData,
    input wire logic [15:0] flashWrData,
    input wire logic        flashEraseStb,
    input wire logic        flashProgStb,
    input wire logic        cpuStall,
    input wire logic        abortReq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ========================================
    // Decoded bus writes
    wire isCtl = regWrStb && regAddr == ADDR_OP_CONTROL;
    wire k55 = regWrStb && regAddr == ADDR_UNLOCK_KEY && regWrData[7:0] == KEY_FIRST;
    wire kAa = regWrStb && regAddr == ADDR_UNLOCK_KEY && regWrData[7:0] == KEY_SECOND;
    sequence s_unlock; k55 ##1 kAa; endsequence
    sequence s_erase; isCtl && regWrData == 16'hc042 && !cpuStall && !abortReq; endsequence
    property p_start; s_unlock ##1 s_erase |=> cpuStall ##[3:5] flashEraseStb; endproperty
    property p_noKey;
        isCtl && regWrData[15] && !cpuStall && !($past(kAa) && $past(k55, 2)) |=> !cpuStall;
    endproperty
    property p_rdIdle; !$past(regRdStb) |-> regRdData == 16'h0000; endproperty
    property p_eGap; flashEraseStb |=> !flashEraseStb [*3]; endproperty
    property p_pGap; flashProgStb |=> !flashProgStb [*3]; endproperty
    property p_excl; !(flashEraseStb && flashProgStb); endproperty
    property p_stall; flashEraseStb || flashProgStb |-> $past(cpuStall); endproperty
    property p_eData; flashEraseStb |-> flashWrData == 16'h0000; endproperty
    property p_abort; cpuStall && abortReq |-> ##[1:2] !cpuStall; endproperty
    // ========================================
    // Assertions
    a_start: assert property (p_start)
        else $error("erase did not start");
    a_noKey: assert property (p_noKey)
        else $error("start without unlock");
    a_rdIdle: assert property (p_rdIdle)
        else $error("read data not zero");
    a_eGap: assert property (p_eGap)
        else $error("erase strobe spacing");
    a_pGap: assert property (p_pGap)
        else $error("program strobe spacing");
    a_excl: assert property (p_excl)
        else $error("erase and program together");
    a_stall: assert property (p_stall)
        else $error("strobe without stall");
    a_eData: assert property (p_eData)
        else $error("erase data not zero");
    a_abort: assert property (p_abort)
        else $error("abort ignored");
endmodule
bind fps_sequencer fps_sequencer_checker chk_u (.*);

// ===== verif/fps_sequencer_tb_top.sv
// Self-checking bench for the flash sequencer
`timescale 1ns/1ps
module fps_sequencer_tb_top;
    import fps_pkg::*;
    logic        clk = 0, rst_n = 0, regWrStb = 0, regRdStb = 0, flashFault = 0, abortReq = 0;
    logic [11:0] regAddr = '0;
    logic [15:0] regWrData = '0, regRdData, rowBufData, flashWrData;
    logic [22:0] tablePage = 23'h001000, flashAddr, lastAddr;
    logic [5:0]  rowBufIdx;
    logic        flashEraseStb, flashProgStb, cpuStall;
    int          num_errors = 0, checks_done = 0, eraseCnt, progCnt, progBad, c0;
    fps_sequencer dut_u (.*);
    fps_flash_model flash_u (.*);
    always #2.5 clk = ~clk;
    // ========================================
    // Bus tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        regAddr <= a;
        regWrData <= d;
        regWrStb <= 1'b1;
        regRdStb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic idle();
        regWrStb <= 1'b0;
        regRdStb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [15:0] e);
        regAddr <= a;
        regRdStb <= 1'b1;
        regWrStb <= 1'b0;
        @(posedge clk);
        regRdStb <= 1'b0;
        #1;
        chk(regRdData, e);
        @(posedge clk);
    endtask
    task automatic waitDone();
        repeat (4000) begin
            @(posedge clk);
            #1;
            if (cpuStall === 1'b0)
                break;
        end
        chk(cpuStall, 0);
        repeat (2) @(posedge clk);
    endtask
    task automatic go(input logic [15:0] d);
        wr(ADDR_UNLOCK_KEY, 16'h0055);
        wr(ADDR_UNLOCK_KEY, 16'h00aa);
        wr(ADDR_OP_CONTROL, d);
        idle();
    endtask
    task automatic print_verdict();
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // ========================================
    // Watchdog
    initial begin
        #100000;
        num_errors++;
        print_verdict();
    end
    // ========================================
    // Test sequence
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd(ADDR_OP_CONTROL, OP_CONTROL_RESET);
        rd(ADDR_UNLOCK_KEY, 16'h0000);
        rd(12'h762, 16'h0000);
        wr(ADDR_OP_CONTROL, 16'h0fb0);
        rd(ADDR_OP_CONTROL, 16'h0000);
        wr(ADDR_OP_CONTROL, 16'hc042);
        rd(ADDR_OP_CONTROL, 16'h6042);
        wr(ADDR_OP_CONTROL, 16'h4042);
        rd(ADDR_OP_CONTROL, 16'h4042);
        c0 = eraseCnt;
        go(16'hc042);
        waitDone();
        chk(eraseCnt - c0, 512);
        chk(lastAddr, 23'h0011ff);
        rd(ADDR_OP_CONTROL, 16'h4042);
        for (int r = 0; r < 2; r++) begin
            tablePage <= 23'h001000 + 23'(64 * r);
            c0 = progCnt;
            go(16'hc001);
            waitDone();
            chk(progCnt - c0, 64);
            chk(lastAddr, 23'h00103f + 23'(64 * r));
            rd(ADDR_OP_CONTROL, 16'h4001);
        end
        chk(progBad, 0);
        wr(ADDR_UNLOCK_KEY, 16'h0055);
        wr(ADDR_OP_CONTROL, 16'h4001);
        wr(ADDR_UNLOCK_KEY, 16'h00aa);
        wr(ADDR_OP_CONTROL, 16'hc001);
        rd(ADDR_OP_CONTROL, 16'h6001);
        wr(ADDR_OP_CONTROL, 16'h4042);
        go(16'hc042);
        repeat (20) @(posedge clk);
        abortReq <= 1'b1;
        @(posedge clk);
        abortReq <= 1'b0;
        waitDone();
        rd(ADDR_OP_CONTROL, 16'h6042);
        wr(ADDR_OP_CONTROL, 16'h4001);
        c0 = progCnt;
        go(16'hc001);
        repeat (20) @(posedge clk);
        flashFault <= 1'b1;
        @(posedge clk);
        flashFault <= 1'b0;
        waitDone();
        chk(progCnt - c0 < 64, 1);
        rd(ADDR_OP_CONTROL, 16'h6001);
        print_verdict();
    end
endmodule
